/* slenc_cfg.svh */
/*
  constants for the status lamp encoder: flash timing, divider width and address width.
  assumes a 100 MHz controller clock.
*/
`ifndef SLENC_CFG_SVH
`define SLENC_CFG_SVH
`define SLENC_CLK_MHZ        100
`define SLENC_FLASH_HALF_MS  250
`define SLENC_FLASH_HALF_CYC (`SLENC_FLASH_HALF_MS * 1000 * `SLENC_CLK_MHZ)
`define SLENC_DIV_W          32
`define SLENC_ADDR_W         6
`endif

/* slenc_pkg.sv */
/*
  types shared by the status lamp encoder files.
  assumes slenc_cfg.svh is compiled first.
*/
package slenc_pkg;
  // lamp colour: bit 0 green element, bit 1 red element
  typedef logic [1:0] slenc_color_t;
  typedef enum logic [2:0]
  {
    SLENC_HS_TEST  = 3'b000,
    SLENC_HS_RUN   = 3'b001
  } slenc_hstate_t;
endpackage : slenc_pkg

/* slenc_flash_div.sv */
/*
  shared flash phase divider for the status lamp encoder.
  assumes one free-running clock; phase toggles every half period.
*/
`timescale 1ns/1ps
`include "slenc_cfg.svh"
module slenc_flash_div
#(
  parameter logic [`SLENC_DIV_W-1:0] HALF_CYC = `SLENC_FLASH_HALF_CYC
)
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_phase
);
  logic [`SLENC_DIV_W-1:0] cnt_reg;
  logic                    phase_reg;
  wire                     wrap = (cnt_reg >= HALF_CYC - 1'b1);

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_reg   <= '0;
      phase_reg <= ~phase_reg;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign o_phase = phase_reg;
endmodule : slenc_flash_div

/* slenc_top.sv */
/*
  status lamp encoder: maps controller status onto lamp patterns for the
  card, serial and network module health lamps.
  assumes status inputs are asynchronous levels; lamps are 2-bit colour.
*/
`timescale 1ns/1ps
`include "slenc_cfg.svh"
module slenc_top
#(
  parameter logic [`SLENC_DIV_W-1:0] HALF_CYC = `SLENC_FLASH_HALF_CYC,
  parameter bit                      HAS_SECOND_CH = 1'b1
)
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_card_busy,
  input  wire logic                     i_card_fs_bad,
  input  wire logic                     i_ser0_default,
  input  wire logic                     i_ser0_traffic,
  input  wire logic                     i_ser1_traffic,
  input  wire logic                     i_ctl_faulted,
  input  wire logic                     i_major_fault,
  input  wire logic                     i_fw_update,
  input  wire logic                     i_fw_invalid,
  input  wire logic                     i_dup_addr,
  input  wire logic                     i_host_started,
  input  wire logic                     i_conn_up,
  input  wire logic [`SLENC_ADDR_W-1:0] i_addr_sw,
  output slenc_pkg::slenc_color_t       o_card_activity_lamp,
  output slenc_pkg::slenc_color_t       o_default_serial_cfg_lamp,
  output slenc_pkg::slenc_color_t       o_first_serial_activity_lamp,
  output slenc_pkg::slenc_color_t       o_second_serial_activity_lamp,
  output slenc_pkg::slenc_color_t       o_module_health_lamp,
  output logic                          o_self_test
);
  import slenc_pkg::*;

  localparam int NS = 12 + `SLENC_ADDR_W;
  localparam slenc_color_t OFF = 2'b00;
  localparam slenc_color_t GRN = 2'b01;
  localparam slenc_color_t RED = 2'b10;

  // two-stage synchronisers, one per input bit
  wire  [NS-1:0] raw = {i_addr_sw, i_conn_up, i_host_started, i_dup_addr,
                        i_fw_invalid, i_fw_update, i_major_fault,
                        i_ctl_faulted, i_ser1_traffic, i_ser0_traffic,
                        i_ser0_default, i_card_fs_bad, i_card_busy};
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_sync
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n)
        begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
        end
        else
        begin
          s1_reg[g] <= raw[g];
          s2_reg[g] <= s1_reg[g];
        end
      end
    end
  endgenerate

  wire card_busy   = s2_reg[0];
  wire card_fs_bad = s2_reg[1];
  wire ser0_def    = s2_reg[2];
  wire ser0_tfc    = s2_reg[3];
  wire ser1_tfc    = s2_reg[4];
  wire ctl_fault   = s2_reg[5];
  wire major_fault = s2_reg[6];
  wire fw_update   = s2_reg[7];
  wire fw_invalid  = s2_reg[8];
  wire dup_addr    = s2_reg[9];
  wire host_start  = s2_reg[10];
  wire conn_up     = s2_reg[11];
  wire [`SLENC_ADDR_W-1:0] addr_sw = s2_reg[NS-1:12];

  // single phase source keeps every flashing lamp in step
  logic phase;
  slenc_flash_div #(.HALF_CYC(HALF_CYC)) u_div
  (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .o_phase (phase)
  );

  // node address latch: taken on the first cycle after synchronisers fill
  logic [1:0]               boot_cnt_reg;
  logic                     addr_held_reg;
  logic [`SLENC_ADDR_W-1:0] addr_boot_reg;
  wire boot_take = (boot_cnt_reg == 2'h2) && !addr_held_reg;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      boot_cnt_reg  <= 2'h0;
      addr_held_reg <= 1'b0;
      addr_boot_reg <= '0;
    end
    else
    begin
      if (boot_cnt_reg != 2'h2)
        boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_take)
      begin
        addr_held_reg <= 1'b1;
        addr_boot_reg <= addr_sw;
      end
    end
  end
  wire addr_moved = addr_held_reg && (addr_sw != addr_boot_reg);

  // health state: self-test until the host has communicated with the card
  slenc_hstate_t hs_reg;
  slenc_hstate_t hs_next;
  always_comb
  begin
    case (hs_reg)
      SLENC_HS_TEST: hs_next = host_start ? SLENC_HS_RUN : SLENC_HS_TEST;
      SLENC_HS_RUN:  hs_next = SLENC_HS_RUN;
      default:       hs_next = SLENC_HS_TEST;
    endcase
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      hs_reg <= SLENC_HS_TEST;
    else
      hs_reg <= hs_next;
  end

  // pattern helpers
  wire          blink   = phase;
  wire          fl_on   = blink;
  slenc_color_t alt_rg;
  assign alt_rg = blink ? RED : GRN;

  // card lamp: fault flashing red outranks activity
  slenc_color_t card_next;
  assign card_next = card_fs_bad ? (fl_on ? RED : OFF) :
                     card_busy   ? (fl_on ? GRN : OFF) :
                                   OFF;

  slenc_color_t dcfg_next;
  assign dcfg_next = ser0_def ? GRN : OFF;

  slenc_color_t ch0_next;
  slenc_color_t ch1_next;
  assign ch0_next = (ser0_tfc && fl_on) ? GRN : OFF;
  assign ch1_next = (HAS_SECOND_CH && ser1_tfc && fl_on) ? GRN : OFF;

  // health lamp priority: faults first, then self-test, then connections
  wire minor = fw_update || fw_invalid || addr_moved || dup_addr;
  slenc_color_t ms_next;
  assign ms_next =
    ctl_fault               ? OFF :
    major_fault             ? RED :
    minor                   ? (fl_on ? RED : OFF) :
    (hs_reg == SLENC_HS_TEST) ? alt_rg :
    conn_up                 ? GRN :
                              (fl_on ? GRN : OFF);

  // every lamp leaves through its own flop so pins never glitch
  slenc_color_t card_reg;
  slenc_color_t dcfg_reg;
  slenc_color_t ch0_reg;
  slenc_color_t ch1_reg;
  slenc_color_t ms_reg;
  logic         st_reg;
  wire          st_next = (hs_next == SLENC_HS_TEST);

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      card_reg <= OFF;
    else
      card_reg <= card_next;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      dcfg_reg <= OFF;
    else
      dcfg_reg <= dcfg_next;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      ch0_reg <= OFF;
    else
      ch0_reg <= ch0_next;
  end

  // with the second channel absent this flop simply stays dark
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      ch1_reg <= OFF;
    else
      ch1_reg <= ch1_next;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      ms_reg <= OFF;
    else
      ms_reg <= ms_next;
  end

  // self-test flag follows the next state so it drops one cycle before the lamp change
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      st_reg <= 1'b1;
    else
      st_reg <= st_next;
  end

  assign o_card_activity_lamp          = card_reg;
  assign o_default_serial_cfg_lamp     = dcfg_reg;
  assign o_first_serial_activity_lamp  = ch0_reg;
  assign o_second_serial_activity_lamp = ch1_reg;
  assign o_module_health_lamp          = ms_reg;
  assign o_self_test                   = st_reg;
endmodule : slenc_top

/* slenc_top_chk.sv */
/* port assertions for slenc_top, bound below.
   assumes inputs change on rising edges. */
`timescale 1ns/1ps
`include "slenc_cfg.svh"
module slenc_top_chk
#(
  parameter logic [`SLENC_DIV_W-1:0] HALF_CYC = `SLENC_FLASH_HALF_CYC
)
(
  input wire logic                    i_mclk,
  input wire logic                    i_rst_n,
  input wire logic                    i_card_busy,
  input wire logic                    i_card_fs_bad,
  input wire logic                    i_ser0_default,
  input wire logic                    i_ser0_traffic,
  input wire logic                    i_ctl_faulted,
  input wire logic                    i_major_fault,
  input wire slenc_pkg::slenc_color_t o_card_activity_lamp,
  input wire slenc_pkg::slenc_color_t o_default_serial_cfg_lamp,
  input wire slenc_pkg::slenc_color_t o_first_serial_activity_lamp,
  input wire slenc_pkg::slenc_color_t o_module_health_lamp
);
  import slenc_pkg::*;
  logic [`SLENC_DIV_W-1:0] lit_run;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_both_flash;
    (i_card_busy && !i_card_fs_bad && i_ser0_traffic)[*4];
  endsequence
  // a card lamp green flash may never outlast one half period of the divider
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || o_card_activity_lamp != 2'h1)
      lit_run <= '0;
    else
      lit_run <= lit_run + 1'b1;
  end
  a_card_dark: assert property (
    (!i_card_busy && !i_card_fs_bad)[*4] |-> o_card_activity_lamp == 2'h0)
    else $error("card lamp lit while idle");
  a_card_green: assert property (
    (i_card_busy && !i_card_fs_bad)[*4] |-> !o_card_activity_lamp[1])
    else $error("card lamp red during access");
  a_card_red: assert property (
    i_card_fs_bad[*4] |-> !o_card_activity_lamp[0])
    else $error("card lamp green on bad file system");
  a_dflt_steady: assert property (
    i_ser0_default[*4] |-> o_default_serial_cfg_lamp == 2'h1)
    else $error("default lamp not steady green");
  a_dflt_off: assert property (
    (!i_ser0_default)[*4] |-> o_default_serial_cfg_lamp == 2'h0)
    else $error("default lamp lit");
  a_ser_idle: assert property (
    (!i_ser0_traffic)[*4] |-> o_first_serial_activity_lamp == 2'h0)
    else $error("serial lamp lit while idle");
  a_flash_sync: assert property (
    s_both_flash |-> o_card_activity_lamp == o_first_serial_activity_lamp)
    else $error("flashing lamps out of phase");
  a_health_off: assert property (
    i_ctl_faulted[*4] |-> o_module_health_lamp == 2'h0)
    else $error("health lamp lit when faulted");
  a_major_red: assert property (
    (!i_ctl_faulted && i_major_fault)[*4] |-> o_module_health_lamp == 2'h2)
    else $error("health lamp not steady red");
  a_green_cap: assert property (lit_run <= HALF_CYC)
    else $error("green flash longer than half period");
endmodule : slenc_top_chk
bind slenc_top slenc_top_chk #(.HALF_CYC(HALF_CYC)) u_chk (.i_mclk, .i_rst_n,
  .i_card_busy, .i_card_fs_bad, .i_ser0_default, .i_ser0_traffic,
  .i_ctl_faulted, .i_major_fault, .o_card_activity_lamp,
  .o_default_serial_cfg_lamp, .o_first_serial_activity_lamp,
  .o_module_health_lamp);

/* slenc_host_model.sv */
/* host side: starts the card some cycles after asked; reports links.
   assumes the encoder clock. */
`timescale 1ns/1ps
module slenc_host_model
#(
  parameter int START_DLY = 6
)
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_go,
  input  wire logic i_conn,
  output logic      o_host_started,
  output logic      o_conn_up
);
  logic [7:0] wait_reg;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || !i_go)
      wait_reg <= 8'h00;
    else if (wait_reg != 8'hff)
      wait_reg <= wait_reg + 8'h01;
  end
  // slow start keeps the card in self-test meanwhile
  assign o_host_started = int'(wait_reg) >= START_DLY;
  assign o_conn_up      = i_conn;
endmodule : slenc_host_model

/* tb.sv */
/* testbench for slenc_top: judges lamp patterns by colours seen.
   assumes HALF_CYC of 4, so 8 samples span a whole flash. */
`timescale 1ns/1ps
`include "slenc_cfg.svh"
module tb;
  import slenc_pkg::*;
  localparam logic [3:0] OFF = 4'h1, SG = 4'h2, FG = 4'h3, SR = 4'h4;
  localparam logic [3:0] FR = 4'h5, ALT = 4'h6;
  logic i_mclk = 0, i_rst_n = 0, i_card_busy = 0, i_card_fs_bad = 0;
  logic i_ser0_default = 0, i_ser0_traffic = 0, i_ser1_traffic = 0;
  logic i_ctl_faulted = 0, i_major_fault = 0, i_fw_update = 0;
  logic i_fw_invalid = 0, i_dup_addr = 0, go = 0, conn = 0;
  logic hs, cu, st;
  logic [`SLENC_ADDR_W-1:0] i_addr_sw = 6'h05;
  slenc_color_t lamp [5];
  int n_errors = 0, cmp_count = 0;
  slenc_host_model HOST (.i_mclk, .i_rst_n, .i_go(go), .i_conn(conn),
    .o_host_started(hs), .o_conn_up(cu));
  slenc_top #(.HALF_CYC(4)) DUT (.*, .i_host_started(hs), .i_conn_up(cu),
    .o_card_activity_lamp(lamp[0]), .o_default_serial_cfg_lamp(lamp[1]),
    .o_first_serial_activity_lamp(lamp[2]),
    .o_second_serial_activity_lamp(lamp[3]),
    .o_module_health_lamp(lamp[4]), .o_self_test(st));
  initial
    forever #5 i_mclk = ~i_mclk;
  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // settle past the sync latency, then mark each colour value shown
  task automatic look(input int k, input logic [3:0] exp);
    logic [3:0] m;
    m = 4'h0;
    repeat (4) @(posedge i_mclk);
    repeat (8)
    begin
      @(negedge i_mclk);
      m[lamp[k]] = 1'b1;
    end
    chk(m, exp);
  endtask : look
  task automatic t_card;
    @(posedge i_mclk) i_card_busy <= 1;
    look(0, FG);
    @(posedge i_mclk) i_card_fs_bad <= 1;
    look(0, FR);
    @(posedge i_mclk) {i_card_busy, i_card_fs_bad} <= 2'h0;
    look(0, OFF);
    $display("card test done");
  endtask : t_card
  task automatic t_serial;
    @(posedge i_mclk) i_ser0_default <= 1;
    look(1, SG);
    @(posedge i_mclk) i_ser0_default <= 0;
    look(1, OFF);
    look(2, OFF);
    @(posedge i_mclk) {i_card_busy, i_ser0_traffic, i_ser1_traffic} <= 3'h7;
    look(3, FG);
    repeat (8)
    begin
      @(negedge i_mclk);
      chk({lamp[0], lamp[2]}, {lamp[3], lamp[3]});
    end
    @(posedge i_mclk) {i_card_busy, i_ser0_traffic, i_ser1_traffic} <= 3'h0;
    $display("serial test done");
  endtask : t_serial
  task automatic t_health;
    int i;
    chk({3'h0, st}, 4'h1);
    look(4, ALT);
    @(posedge i_mclk) go <= 1;
    for (i = 0; i < 40 && st !== 1'b0; i++)
      @(posedge i_mclk);
    if (i == 40)
    begin
      n_errors++;
      report_and_stop();
    end
    look(4, FG);
    @(posedge i_mclk) conn <= 1;
    look(4, SG);
    for (i = 0; i < 4; i++)
    begin
      @(posedge i_mclk) {i_fw_update, i_fw_invalid, i_dup_addr} <= 3'h4 >> i;
      i_addr_sw <= (i == 3) ? 6'h06 : 6'h05;
      look(4, FR);
    end
    @(posedge i_mclk) i_addr_sw <= 6'h05;
    look(4, SG);
    @(posedge i_mclk) i_major_fault <= 1;
    look(4, SR);
    @(posedge i_mclk) i_ctl_faulted <= 1;
    look(4, OFF);
    $display("health test done");
  endtask : t_health
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1;
    t_card();
    t_serial();
    t_health();
    report_and_stop();
  end
endmodule : tb
